/* File: touch_irq_pkg.sv */
// Package for the touch interrupt output block: register map, field layout, reset values.
// Assumes an AXI4-Lite slave with 32-bit data; each 16-bit register sits in one aligned word.
package touch_irq_pkg;

    // Printed offsets are not multiples of four, so they are word indices
    localparam logic [9:0] idx_low_mask = 10'h005;
    localparam logic [9:0] idx_high_mask = 10'h006;
    localparam logic [9:0] idx_done_mask = 10'h007;
    localparam logic [9:0] idx_low_flags = 10'h008;
    localparam logic [9:0] idx_high_flags = 10'h009;
    localparam logic [9:0] idx_done_flags = 10'h00a;
    localparam logic [9:0] idx_pin_in = 10'h00b;
    localparam int addr_w = 12;

    // Field positions inside the low-threshold mask register
    localparam int pin_func_lo = 12;
    localparam int trig_sel_lo = 14;
    // Stage events occupy bits 11:0, pin flag and pin mask sit at bit 15
    localparam int stages = 12;
    localparam int pin_bit = 15;

    // Pin function codes
    localparam logic [1:0] pin_off = 2'h0;
    localparam logic [1:0] pin_input = 2'h1;
    localparam logic [1:0] pin_out_low = 2'h2;
    localparam logic [1:0] pin_out_high = 2'h3;

    // Trigger select codes
    localparam logic [1:0] trig_low_level = 2'h0;
    localparam logic [1:0] trig_rise = 2'h1;
    localparam logic [1:0] trig_fall = 2'h2;
    localparam logic [1:0] trig_high_level = 2'h3;

    localparam logic [15:0] mask_reset = 16'h0000;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // Stage events from the conversion logic
    typedef struct packed {
        logic [11:0] low_exceed;
        logic [11:0] high_exceed;
        logic [11:0] conv_done;
    } stage_event_type;

    // Decoded pin configuration
    typedef struct packed {
        logic [1:0] func;
        logic [1:0] trig;
        logic enable;
    } pin_cfg_type;

endpackage

/* File: pin_trigger.sv */
// Pin trigger detector: edge or level condition for the general-purpose input.
// Assumes the pin is synchronous to clk.
`timescale 1ns/10ps
module pin_trigger (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    input wire touch_irq_pkg::pin_cfg_type cfg,
    output logic fire,
    output logic holding
);
    logic pin_q; // Previous pin level for edge detection
    logic armed;
    logic rise;
    logic fall;

    // Only an enabled input pin can trigger
    assign armed = cfg.enable && (cfg.func == touch_irq_pkg::pin_input);
    assign rise = pin_in && !pin_q;
    assign fall = !pin_in && pin_q;

    // Trigger decode per select code
    always_comb begin
        fire = 1'b0;
        holding = 1'b0;
        case (cfg.trig)
            touch_irq_pkg::trig_low_level: begin
                fire = !pin_in;
                holding = !pin_in;
            end
            touch_irq_pkg::trig_rise: begin
                fire = rise;
            end
            touch_irq_pkg::trig_fall: begin
                fire = fall;
            end
            touch_irq_pkg::trig_high_level: begin
                fire = pin_in;
                holding = pin_in;
            end
            default: begin
                fire = 1'b0;
            end
        endcase
        fire = fire && armed;
        holding = holding && armed;
    end

    // Pin history register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_in;
        end
    end
endmodule

/* File: sticky_flags.sv */
// Bank of sticky flags: set by events, cleared on a read unless the cause still holds.
// Assumes read strobe is one cycle per completed bus read.
`timescale 1ns/10ps
module sticky_flags (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] set_in,
    input wire logic [15:0] hold_in,
    input wire logic read_clr,
    output logic [15:0] flags
);
    logic [15:0] flags_d; // Next flag values

    // Set wins over clear so a coincident event is not lost
    assign flags_d = set_in | hold_in | (read_clr ? 16'h0000 : flags);

    // Flag storage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= 16'h0000;
        end else begin
            flags <= flags_d;
        end
    end
endmodule

/* File: touch_gpio_irq_output.sv */
// Interrupt output logic of a touch controller, with AXI4-Lite register access.
// Assumes stage events are single-cycle pulses and the pin is synchronous to clk.
// Flags clear only when the host reads their word.
// Function
// - Pin drives interrupt only in input mode
// - Pin interrupt mask bit in 0x007
// - Pin flag sets when pin triggered interrupt
// - Read clears pin flag unless condition holds
// - Four pin triggers chosen by select field
// - Enabled exceeded low threshold asserts interrupt
// - Uncrossed enabled stage never asserts interrupt
// - Interrupt released only after status readback
// - Separate per-stage low, high, done enables
// - Pin function field at bits 13:12
// - Trigger select decode low/rise/fall/high
// - Edge modes pulse interrupt once
// - Level modes hold interrupt while level
`timescale 1ns/10ps
module touch_gpio_irq_output (
    input wire logic clk,
    input wire logic sys_rst,
    // Stage events from the conversion logic
    input wire touch_irq_pkg::stage_event_type stage_ev,
    // General-purpose pin
    input wire logic gpio_in,
    // Drive used in output modes only
    output logic gpio_out,
    output logic gpio_oe,
    // Active-low interrupt to the host
    output logic irq_n,
    // AXI4-Lite slave
    // Write address channel
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Word index from a byte address
    // Low two address bits are ignored
    function automatic logic [9:0] word_idx(input logic [11:0] a);
        word_idx = a[11:2];
    endfunction

    // Mask registers
    // Low mask holds pin setup too
    logic [15:0] low_mask_q;
    logic [15:0] high_mask_q;
    // Bit 15 is the pin enable
    logic [15:0] done_mask_q;

    // Write channel holding
    // Halves park until both arrive
    logic aw_held_q;
    logic [11:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    // Response stands until taken
    logic bvalid_q;
    logic [1:0] bresp_q;

    // Read channel holding
    // One read outstanding at most
    logic rvalid_q;
    // Response code kept with data
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Flag banks
    // One sticky bank per kind
    logic [15:0] low_flags;
    logic [15:0] high_flags;
    // Bit 15 is the pin flag
    logic [15:0] done_flags;

    // Pin trigger outputs
    // Fire sets, hold keeps the flag
    logic pin_fire;
    logic pin_hold;
    touch_irq_pkg::pin_cfg_type pin_cfg;

    // Stage events gated by per-stage enables
    // Bits above the stages are zero, except done_set bit 15, which carries the pin
    logic [15:0] low_set;
    logic [15:0] high_set;
    logic [15:0] done_set;
    logic [15:0] done_hold;

    // Bus decode wires
    // Write side
    logic do_write;
    logic [9:0] wr_idx;
    // Read side
    logic [9:0] rd_idx;
    logic rd_take;
    logic rd_mapped;
    logic wr_mapped;
    logic [15:0] wr_data16;
    logic [15:0] rd_value;
    // Read-to-clear strobes
    logic clr_low;
    logic clr_high;
    logic clr_done;
    // Masks after a write
    logic [15:0] low_mask_d;
    logic [15:0] high_mask_d;
    logic [15:0] done_mask_d;

    // Pin configuration fields live in the low mask register
    // Setup sits above the stage bits
    assign pin_cfg.func = low_mask_q[touch_irq_pkg::pin_func_lo +: 2];
    assign pin_cfg.trig = low_mask_q[touch_irq_pkg::trig_sel_lo +: 2];
    // Enable lives in the done mask
    assign pin_cfg.enable = done_mask_q[touch_irq_pkg::pin_bit];

    // Output modes never arm the pin
    pin_trigger u_pin (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(gpio_in),
        .cfg(pin_cfg),
        .fire(pin_fire),
        .holding(pin_hold)
    );

    // Per-stage gating keeps untouched or disabled stages silent
    // Masks apply at set time
    genvar g;
    generate
        for (g = 0; g < touch_irq_pkg::stages; g = g + 1) begin : g_stage
            assign low_set[g] = stage_ev.low_exceed[g] && low_mask_q[g];
            assign high_set[g] = stage_ev.high_exceed[g] && high_mask_q[g];
            assign done_set[g] = stage_ev.conv_done[g] && done_mask_q[g];
        end
    endgenerate
    // Unused upper bank bits
    assign low_set[15:12] = 4'h0;
    assign high_set[15:12] = 4'h0;
    assign done_set[14:12] = 3'h0;
    // Pin rides on the top bit
    assign done_set[15] = pin_fire;
    // A standing level survives a read
    assign done_hold = {pin_hold, 15'h0000};

    // Low-threshold flags, cleared by reading their word
    // No hold term here
    sticky_flags u_low (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(low_set),
        .hold_in(16'h0000),
        .read_clr(clr_low),
        .flags(low_flags)
    );

    // High-threshold flags
    // No hold term here
    sticky_flags u_high (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(high_set),
        .hold_in(16'h0000),
        .read_clr(clr_high),
        .flags(high_flags)
    );

    // Conversion-complete flags with pin flag on top bit
    // Level hold on bit 15 only
    sticky_flags u_done (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_in(done_set),
        .hold_in(done_hold),
        .read_clr(clr_done),
        .flags(done_flags)
    );

    // Interrupt low while any flag stands; an edge pulse latched into its flag
    // holds the line low, so edge triggers give one low period until read
    // No output flop: no extra lag
    // A later mask change keeps the flag
    assign irq_n = ~(|low_flags | |high_flags | |done_flags);

    // Pin output drive for output modes
    // The pin is still read meanwhile
    // Codes 10 and 11 drive the pin
    assign gpio_oe = pin_cfg.func[1];
    // High only for code 11
    assign gpio_out = (pin_cfg.func == touch_irq_pkg::pin_out_high);

    // Write path: take address and data in either order
    // No new write while one stands
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    // Decode the parked address
    assign wr_idx = word_idx(aw_addr_q);
    assign wr_mapped = (wr_idx == touch_irq_pkg::idx_low_mask) ||
                       (wr_idx == touch_irq_pkg::idx_high_mask) ||
                       (wr_idx == touch_irq_pkg::idx_done_mask);
    // Upper half of data unused
    assign wr_data16 = w_data_q[15:0];

    // Byte-lane merged next mask values
    // Lane 1 is the upper byte
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] strb);
        merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // Other words leave masks alone
    assign low_mask_d = (do_write && wr_idx == touch_irq_pkg::idx_low_mask) ?
                        merge(low_mask_q, wr_data16, w_strb_q) : low_mask_q;
    assign high_mask_d = (do_write && wr_idx == touch_irq_pkg::idx_high_mask) ?
                         merge(high_mask_q, wr_data16, w_strb_q) : high_mask_q;
    assign done_mask_d = (do_write && wr_idx == touch_irq_pkg::idx_done_mask) ?
                         merge(done_mask_q, wr_data16, w_strb_q) : done_mask_q;

    // Address and data capture
    // Either order; both before write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (do_write) begin
            // Both halves used; free slots
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            // Park whichever half is offered
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response
    // Slave error for unmapped words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= touch_irq_pkg::resp_okay;
        end else if (do_write) begin
            // Rises with the register update
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? touch_irq_pkg::resp_okay : touch_irq_pkg::resp_slverr;
        end else if (s_axi_bready) begin
            // Host took the response
            bvalid_q <= 1'b0;
        end
    end
    // Outputs straight from flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Mask registers; enables steer the flag logic
    // Reset clears every enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_mask_q <= touch_irq_pkg::mask_reset;
            high_mask_q <= touch_irq_pkg::mask_reset;
            done_mask_q <= touch_irq_pkg::mask_reset;
        end else begin
            // Hold or take the merged value
            low_mask_q <= low_mask_d;
            high_mask_q <= high_mask_d;
            // Pin enable rides here
            done_mask_q <= done_mask_d;
        end
    end

    // Read path: one read at a time, answered the cycle after the address
    assign s_axi_arready = !rvalid_q;
    assign rd_take = s_axi_arvalid && !rvalid_q;
    // Live address must stand until taken
    assign rd_idx = word_idx(s_axi_araddr);
    // First mask through pin level
    assign rd_mapped = (rd_idx >= touch_irq_pkg::idx_low_mask) &&
                       (rd_idx <= touch_irq_pkg::idx_pin_in);
    // Unmapped words read zero
    assign rd_value = (rd_idx == touch_irq_pkg::idx_low_mask) ? low_mask_q :
                      (rd_idx == touch_irq_pkg::idx_high_mask) ? high_mask_q :
                      (rd_idx == touch_irq_pkg::idx_done_mask) ? done_mask_q :
                      (rd_idx == touch_irq_pkg::idx_low_flags) ? low_flags :
                      (rd_idx == touch_irq_pkg::idx_high_flags) ? high_flags :
                      (rd_idx == touch_irq_pkg::idx_done_flags) ? done_flags :
                      (rd_idx == touch_irq_pkg::idx_pin_in) ? {15'h0000, gpio_in} :
                      16'h0000;

    // Reading a status word clears its flags as the value is captured
    // Set wins, so no event is lost
    // Mask and pin reads clear nothing
    assign clr_low = rd_take && (rd_idx == touch_irq_pkg::idx_low_flags);
    assign clr_high = rd_take && (rd_idx == touch_irq_pkg::idx_high_flags);
    assign clr_done = rd_take && (rd_idx == touch_irq_pkg::idx_done_flags);

    // Read data register
    // Data stands until rready
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= touch_irq_pkg::resp_okay;
        end else if (rd_take) begin
            // Capture word and response
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_value};
            rresp_q <= rd_mapped ? touch_irq_pkg::resp_okay : touch_irq_pkg::resp_slverr;
        end else if (s_axi_rready) begin
            // Host took the data
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

/* File: touch_irq_props.sv */
// Checker for the touch interrupt block, watching its top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module touch_irq_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irq_n,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Readable words are indices 5 to 0xB only
    wire logic rd_bad = s_axi_araddr[11:2] < 10'h005 || s_axi_araddr[11:2] > 10'h00b;
    a_irq_held: assert property (!irq_n && !s_axi_arvalid |=> !irq_n)
        else $error("interrupt released without a status read");
    a_irq_rise: assert property ($rose(irq_n) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("interrupt rose without a read taken before");
    a_wr_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_rd_unmapped: assert property (rd_taken and rd_bad |=>
        s_axi_rresp == touch_irq_pkg::resp_slverr && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    a_pin_drive: assert property (gpio_out |-> gpio_oe)
        else $error("pin driven high without enable");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

/* File: axi_host.sv */
// Host model: AXI4-Lite master reading and writing the block's registers.
// Assumes one task at a time; slow holds response ready low for four cycles.
`timescale 1ns/10ps
module axi_host (
    input wire logic clk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    logic slow = 1'b0; // Delays ready to test a standing response
    logic tout = 1'b0; // Set when a transfer never finishes
    initial {awvalid, wvalid, bready, arvalid, rready} = 5'h0_0;
    initial {awaddr, araddr, wdata, wstrb} = 60'h0;
    // Write: both halves offered, each released with a changed pattern once taken
    task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        {awvalid, wvalid, bready} <= {2'b11, !slow};
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~{16'h0000, d};
            end
            if (n == 3) bready <= 1'b1;
            if (bvalid && bready) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 300) tout = 1'b1;
    endtask
    // Read: status words are cleared by this read, as the host must do to release irq
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= {1'b1, !slow};
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (n == 3) rready <= 1'b1;
            if (rvalid && rready) break;
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        if (n == 300) tout = 1'b1;
    endtask
endmodule

/* File: tb.sv */
// Testbench: host model on the register bus, stage events and pin driven here.
// Assumes the block answers on its own; every wait is bounded in the host.
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h, expected %h", $time, (a), (e)); end end
module tb;
    logic clk, sys_rst, gpio_in, gpio_out, gpio_oe, irq_n;
    touch_irq_pkg::stage_event_type ev; // Stage events, one-cycle pulses
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count = 0;
    int num_checks = 0;
    touch_gpio_irq_output uut (.clk, .sys_rst, .stage_ev(ev), .gpio_in, .gpio_out, .gpio_oe,
        .irq_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    axi_host host (.clk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
        .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Let the edge's updates land before looking
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A stuck transfer ends the run when its test finishes
    task automatic fin(input string s);
        $display("test %s finished", s);
        if (host.tout) begin
            err_count++;
            end_sim;
        end
    endtask
    // Mask reset values, readback, refused accesses, slow host
    task automatic t_regs;
        logic [11:0] a;
        logic [31:0] d;
        logic [1:0] r;
        host.slow = 1'b1;
        for (a = 12'h014; a < 12'h020; a += 12'h004) begin
            host.rd(a, d, r);
            `CHK(d, 32'h0000_0000)
            host.wr(a, {4'h0, a}, r);
            `CHK(r, touch_irq_pkg::resp_okay)
            host.rd(a, d, r);
            `CHK(d, {20'h0_0000, a})
            host.wr(a, 16'h0000, r);
        end
        host.rd(12'h030, d, r);
        `CHK({r, d}, {touch_irq_pkg::resp_slverr, 32'h0000_0000})
        host.wr(12'h020, 16'hffff, r); // Flags word is not writable
        `CHK(r, touch_irq_pkg::resp_slverr)
        host.slow = 1'b0;
        fin("regs");
    endtask
    // Stages 0, 6, 9 enabled; 0 and 9 cross, disabled stages and kinds also fire
    task automatic t_touch;
        logic [31:0] d;
        logic [1:0] r;
        host.wr(12'h014, 16'h0241, r);
        host.wr(12'h01c, 16'h0020, r);
        @(posedge clk);
        ev <= {12'h209, 12'h001, 12'h010};
        @(posedge clk);
        ev <= '0;
        settle;
        `CHK(irq_n, 1'b0)
        host.rd(12'h020, d, r);
        `CHK(d, 32'h0000_0201)
        settle;
        `CHK(irq_n, 1'b1)
        host.rd(12'h024, d, r);
        `CHK(d, 32'h0000_0000)
        host.rd(12'h028, d, r);
        `CHK(d, 32'h0000_0000)
        @(posedge clk);
        ev <= {12'h000, 12'h000, 12'h020};
        @(posedge clk);
        ev <= '0;
        settle;
        `CHK(irq_n, 1'b0)
        host.rd(12'h028, d, r);
        `CHK(d, 32'h0000_0020)
        host.wr(12'h018, 16'h0001, r);
        @(posedge clk);
        ev <= {12'h000, 12'h001, 12'h000};
        @(posedge clk);
        ev <= '0;
        host.rd(12'h024, d, r);
        `CHK(d, 32'h0000_0001)
        fin("touch");
    endtask
    // Every trigger code: fire, read the pin flag, release
    task automatic t_pin;
        logic [2:0] t;
        logic idle;
        logic [31:0] d;
        logic [1:0] r;
        host.wr(12'h01c, 16'h8000, r);
        for (t = 3'h0; t < 3'h4; t++) begin
            idle = (t == 3'h0 || t == 3'h2);
            @(posedge clk);
            gpio_in <= idle;
            host.wr(12'h014, {t[1:0], 2'b01, 12'h000}, r);
            host.rd(12'h028, d, r);
            settle;
            `CHK(irq_n, 1'b1)
            gpio_in <= !idle;
            repeat (3) @(posedge clk);
            #1;
            `CHK(irq_n, 1'b0)
            host.rd(12'h028, d, r);
            `CHK(d[15], 1'b1)
            settle;
            `CHK(irq_n, t[0] ^ t[1])
            gpio_in <= idle;
            repeat (2) @(posedge clk);
            host.rd(12'h028, d, r);
            settle;
            `CHK(irq_n, 1'b1)
        end
        fin("pin");
    endtask
    // Pin outside input mode, or masked, never raises irq; output drive decode
    task automatic t_pin_off;
        logic [2:0] f;
        logic [1:0] fn;
        logic [1:0] r;
        for (f = 3'h0; f < 3'h4; f++) begin
            fn = f[1:0] ^ 2'b01; // Masked input mode comes first
            @(posedge clk);
            gpio_in <= 1'b0;
            host.wr(12'h014, {2'b11, fn, 12'h000}, r);
            host.wr(12'h01c, (fn == 2'b01) ? 16'h0000 : 16'h8000, r);
            @(posedge clk);
            gpio_in <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            `CHK(irq_n, 1'b1)
            `CHK(gpio_oe, fn[1])
            `CHK(gpio_out, fn == 2'b11)
        end
        fin("pin_off");
    endtask
    initial begin
        sys_rst = 1'b1;
        ev = '0;
        gpio_in = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_touch;
        t_pin;
        t_pin_off;
        end_sim;
    end
endmodule
bind touch_gpio_irq_output touch_irq_props chk (.clk, .sys_rst, .irq_n, .gpio_out, .gpio_oe,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
